// ### diag_channel.sv
// one channel: restart, recheck and diagnostic cycle sequencing with fault capture
`default_nettype none
module diag_channel (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // timebase and host events
  input wire logic i_tick,
  input wire logic i_read_done,
  input wire logic i_diag_en,
  input wire logic i_line_sel,
  // synchronised raw faults
  input wire diag_pkg::fault_raw_t i_raw,
  // results
  output logic o_enable,
  output logic o_done,
  output diag_pkg::fault_rep_t o_rep
);
  typedef enum logic [2:0] {ST_ACTIVE, ST_RESTART, ST_RECHECK, ST_CYCLE} ch_state_t;
  ch_state_t state_q, state_d;
  logic [7:0] tick_cnt_q, tick_cnt_d;      // 1 ms ticks within the cycle
  diag_pkg::fault_rep_t stable_q, stable_d; // faults still stable this cycle
  diag_pkg::fault_rep_t rep_q, rep_d;       // results held for the host
  logic done_q, done_d;
  logic armed_q, armed_d;                   // a cycle may start; spent at cycle end, renewed by a read
  diag_pkg::fault_rep_t now;                // prioritised fault picture

  // pair priority: a positive ground short with a supply short reports both,
  // a negative ground short yields to supply, shorts win over a shorted load
  always_comb
  begin
    now.vs = i_raw.vs;
    now.gnd = i_raw.gnd_pos | (i_raw.gnd_neg & ~i_raw.vs);
    now.load = (i_line_sel ? i_raw.load_ld : i_raw.load_pa) & ~now.vs & ~now.gnd;
    now.ofs = 1'b0;
  end

  // next state of the channel sequencer
  always_comb
  begin
    state_d = state_q;
    tick_cnt_d = tick_cnt_q;
    stable_d = stable_q;
    rep_d = rep_q;
    done_d = done_q;
    armed_d = armed_q;
    if (i_read_done)
    begin
      done_d = 1'b0;
    end
    case (state_q)
      ST_ACTIVE:
      begin
        if (i_raw.overload)
        begin
          // disabled or spent diagnostics only shut this channel
          state_d = (i_diag_en && armed_q) ? ST_RECHECK : ST_RESTART;
          tick_cnt_d = '0;
        end
      end
      ST_RESTART:
      begin
        // sample once per ms; restart when clear, else a re-armed cycle may begin
        if (i_tick && !i_raw.overload)
        begin
          state_d = ST_ACTIVE;
        end
        else if (i_tick && i_diag_en && armed_q)
        begin
          state_d = ST_RECHECK;
          tick_cnt_d = '0;
        end
      end
      ST_RECHECK:
      begin
        // the tick grid runs free, so the first tick only opens the wait;
        // the check lands one to two ms after entry, never a clock too soon
        if (i_tick && tick_cnt_q == '0)
        begin
          tick_cnt_d = tick_cnt_q + 8'd1;
        end
        else if (i_tick)
        begin
          if (!i_raw.overload)
          begin
            state_d = ST_ACTIVE;
          end
          else
          begin
            state_d = ST_CYCLE;
            tick_cnt_d = '0;
            stable_d = now;
          end
        end
      end
      ST_CYCLE:
      begin
        stable_d = stable_q & now;
        if (i_tick)
        begin
          tick_cnt_d = tick_cnt_q + 8'd1;
          if (tick_cnt_q == 8'(diag_pkg::CYCLE_TICKS - 1))
          begin
            rep_d = stable_q & now;
            done_d = 1'b1;
            armed_d = 1'b0;
            state_d = ST_RESTART;
          end
        end
      end
      default:
      begin
        state_d = ST_ACTIVE;
      end
    endcase
    // a read re-arms the cycles; it wins over a cycle ending in the same clock
    if (i_read_done)
    begin
      armed_d = 1'b1;
    end
    // defeating diagnostics drops a pending check or cycle back to restart mode
    if (!i_diag_en && (state_q == ST_RECHECK || state_q == ST_CYCLE))
    begin
      state_d = ST_RESTART;
    end
    // a read of a healthy channel empties its results, so a cleared fault shows one read late
    if (state_q == ST_ACTIVE && i_read_done)
    begin
      rep_d = '0;
    end
  end

  // register the channel state
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= ST_ACTIVE;
      tick_cnt_q <= '0;
      stable_q <= '0;
      rep_q <= '0;
      done_q <= 1'b0;
      armed_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      tick_cnt_q <= tick_cnt_d;
      stable_q <= stable_d;
      rep_q <= rep_d;
      done_q <= done_d;
      armed_q <= armed_d;
    end
  end

  assign o_enable = (state_q == ST_ACTIVE);
  assign o_done = done_q;
  assign o_rep = rep_q;
endmodule
`default_nettype wire

// ### diag_host_model.sv
// host controller model: writes instruction bytes and ends reads
`default_nettype none
module diag_host_model (
  // core clock
  input wire logic i_core_clk,
  // bytes and strobes towards the block
  output logic [7:0] o_ib1,
  output logic [7:0] o_ib2,
  output logic o_write_done,
  output logic o_read_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus until the bench asks
  initial
  begin
    o_ib1 = 8'h00;
    o_ib2 = 8'h00;
    o_write_done = 1'b0;
    o_read_done = 1'b0;
  end
  // one write, strobe lasts one core cycle
  task automatic wr(input logic [7:0] b1, input logic [7:0] b2);
    @(negedge i_core_clk);
    o_ib1 = b1;
    o_ib2 = b2;
    o_write_done = 1'b1;
    @(negedge i_core_clk);
    o_write_done = 1'b0;
  endtask
  // end of a result read, polled at the host's own pace
  task automatic rd();
    @(negedge i_core_clk);
    o_read_done = 1'b1;
    @(negedge i_core_clk);
    o_read_done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### diag_pkg.sv
// shared constants and types for the output fault diagnostic sequencer
`default_nettype none
package diag_pkg;
  localparam int NUM_CH = 4;                         // four bridge channels
  localparam int CLK_HZ = 50_000_000;                // core clock rate
  localparam int CHECK_US = 1000;                    // recheck interval, 1 ms
  localparam int CYCLE_MS = 100;                     // diagnostic cycle length
  localparam int CHECK_CYC = CLK_HZ / 1_000_000 * CHECK_US;
  localparam int CYCLE_TICKS = CYCLE_MS * 1000 / CHECK_US;  // cycle length in 1 ms ticks
  // first instruction byte fields
  localparam int IB1_CLIP_BIT = 0;
  localparam int IB1_REAR_GAIN_BIT = 3;
  localparam int IB1_FRONT_GAIN_BIT = 4;
  localparam int IB1_OFFSET_EN_BIT = 5;
  localparam int IB1_DIAG_EN_BIT = 6;
  // second instruction byte fields
  localparam int IB2_LINE_DRV_BIT = 3;
  // diagnostic byte fields
  localparam int DB_GND_BIT = 0;
  localparam int DB_VS_BIT = 1;
  localparam int DB_OFS_BIT = 2;
  localparam int DB_LOAD_BIT = 3;
  localparam int DB1_DONE_BIT = 6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // raw fault indications of one channel from the analog comparators
  typedef struct packed {
    logic gnd_pos;       // positive (source) output shorted to ground
    logic gnd_neg;       // negative (sink) output shorted to ground
    logic vs;            // output shorted to supply
    logic load_pa;       // load below power-amplifier threshold
    logic load_ld;       // load below line-driver threshold
    logic offset;        // dc offset beyond limit
    logic overload;      // short-circuit protection tripped
  } fault_raw_t;
  // reported flags of one channel
  typedef struct packed {
    logic load;
    logic ofs;
    logic vs;
    logic gnd;
  } fault_rep_t;
endpackage
`default_nettype wire

// ### diag_seq.sv
// top of the output fault diagnostic sequencer: timebase, offset window, result bytes
// Contract
// - disabled diagnostics: per-channel shutdown on fault
// - restart mode rechecks every 1 ms
// - host-armed diagnostics self-start on overload
// - recheck after 1 ms; clear returns active
// - persistent overload starts 100 ms cycle
// - cycle end: restart channel, store results
// - next cycle waits for a host read
// - line-driver load threshold needs 16 dB
// - offset beyond 2 V flags fault
// - offset window: last read or enable
// - offset flagged only if persistent throughout
// - overload during offset test cancels it
// - several faults: report at least one
// - fault pair priority per table
// - short with open speaker is double fault
// - report only faults stable all cycle
// - read re-arms cycles, returns previous results
// - clip threshold follows configuration bit
// - diag-enable and offset-enable bits act
// - done flag at bit six
// - second byte bit three selects thresholds
// - channel byte bits: load ofs vs gnd
`default_nettype none
module diag_seq #(
  parameter int CHECK_CYCLES = diag_pkg::CHECK_CYC  // clocks per 1 ms tick
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // instruction bytes as written by the host, with write strobe
  input wire logic [7:0] i_first_instruction_byte,
  input wire logic [7:0] i_second_instruction_byte,
  input wire logic i_write_done,
  // end of a host read transaction
  input wire logic i_read_done,
  // raw fault levels from the analog side, asynchronous
  input wire diag_pkg::fault_raw_t [diag_pkg::NUM_CH-1:0] i_fault_raw,
  // channel control
  output logic [diag_pkg::NUM_CH-1:0] o_ch_enable,
  output logic o_clip_detector_sel10,
  // result bytes to the host, one per channel
  output logic [7:0] o_diag_byte [diag_pkg::NUM_CH]
);
  localparam int NCH = diag_pkg::NUM_CH;
  logic [$clog2(CHECK_CYCLES)-1:0] tb_cnt_q, tb_cnt_d;  // free-running timebase
  logic tick_q, tick_d;
  logic [7:0] ib1_q, ib1_d;
  logic [7:0] ib2_q, ib2_d;
  logic ofs_arm_q, ofs_arm_d;              // offset window open
  logic [NCH-1:0] ofs_ok_q, ofs_ok_d;      // offset persisted so far
  logic [NCH-1:0] ofs_rep_q, ofs_rep_d;    // offset result from last window
  logic [NCH-1:0] en_q;
  logic clip_q;
  logic [7:0] byte_q [NCH];
  logic [7:0] byte_d [NCH];
  diag_pkg::fault_raw_t [NCH-1:0] raw_s;
  diag_pkg::fault_rep_t [NCH-1:0] rep;
  logic [NCH-1:0] done;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] line_sel;

  // raw levels come from another domain
  diag_sync #(
    .WIDTH($bits(i_fault_raw))
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_fault_raw),
    .o_sync(raw_s)
  );

  // line-driver threshold only with the 16 dB gain of that channel pair
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      line_sel[c] = ib2_q[diag_pkg::IB2_LINE_DRV_BIT] &
        ((c < NCH / 2) ? ib1_q[diag_pkg::IB1_FRONT_GAIN_BIT] : ib1_q[diag_pkg::IB1_REAR_GAIN_BIT]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      diag_channel u_ch (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_read_done(i_read_done),
        .i_diag_en(ib1_q[diag_pkg::IB1_DIAG_EN_BIT]),
        .i_line_sel(line_sel[g]),
        .i_raw(raw_s[g]),
        .o_enable(ch_en[g]),
        .o_done(done[g]),
        .o_rep(rep[g])
      );
    end
  endgenerate

  // timebase: one tick per 1 ms independent of the host clock
  always_comb
  begin
    tick_d = 1'b0;
    tb_cnt_d = tb_cnt_q + 1'b1;
    if (tb_cnt_q == ($clog2(CHECK_CYCLES))'(CHECK_CYCLES - 1))
    begin
      tb_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  // configuration and offset window
  always_comb
  begin
    ib1_d = ib1_q;
    ib2_d = ib2_q;
    ofs_arm_d = ofs_arm_q;
    ofs_ok_d = ofs_ok_q;
    ofs_rep_d = ofs_rep_q;
    if (ofs_arm_q)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        // must hold every cycle; overload cancels the test
        ofs_ok_d[c] = ofs_ok_q[c] & raw_s[c].offset & ~raw_s[c].overload;
      end
    end
    if (i_read_done)
    begin
      // close at this read, reopen for the next one only while offset enable is set
      ofs_rep_d = ofs_arm_q ? ofs_ok_q : '0;
      ofs_ok_d = '1;
      ofs_arm_d = ib1_q[diag_pkg::IB1_OFFSET_EN_BIT];
    end
    if (i_write_done)
    begin
      ib1_d = i_first_instruction_byte;
      ib2_d = i_second_instruction_byte;
      if (i_first_instruction_byte[diag_pkg::IB1_OFFSET_EN_BIT] && !ib1_q[diag_pkg::IB1_OFFSET_EN_BIT])
      begin
        ofs_arm_d = 1'b1;
        ofs_ok_d = '1;
      end
      else if (!i_first_instruction_byte[diag_pkg::IB1_OFFSET_EN_BIT])
      begin
        ofs_arm_d = 1'b0;
      end
    end
  end

  // assemble per-channel result bytes
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      byte_d[c] = diag_pkg::BYTE_ZERO;
      byte_d[c][diag_pkg::DB_GND_BIT] = rep[c].gnd;
      byte_d[c][diag_pkg::DB_VS_BIT] = rep[c].vs;
      byte_d[c][diag_pkg::DB_LOAD_BIT] = rep[c].load;
      byte_d[c][diag_pkg::DB_OFS_BIT] = ofs_rep_q[c];
    end
    byte_d[0][diag_pkg::DB1_DONE_BIT] = |done;
  end

  // register everything; outputs straight from flops
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tb_cnt_q <= '0;
      tick_q <= 1'b0;
      ib1_q <= diag_pkg::BYTE_ZERO;
      ib2_q <= diag_pkg::BYTE_ZERO;
      ofs_arm_q <= 1'b0;
      ofs_ok_q <= '0;
      ofs_rep_q <= '0;
      en_q <= '0;
      clip_q <= 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
        byte_q[c] <= diag_pkg::BYTE_ZERO;
      end
    end
    else
    begin
      tb_cnt_q <= tb_cnt_d;
      tick_q <= tick_d;
      ib1_q <= ib1_d;
      ib2_q <= ib2_d;
      ofs_arm_q <= ofs_arm_d;
      ofs_ok_q <= ofs_ok_d;
      ofs_rep_q <= ofs_rep_d;
      en_q <= ch_en;
      clip_q <= ib1_q[diag_pkg::IB1_CLIP_BIT];
      for (int c = 0; c < NCH; c++)
      begin
        byte_q[c] <= byte_d[c];
      end
    end
  end

  assign o_ch_enable = en_q;
  assign o_clip_detector_sel10 = clip_q;
  assign o_diag_byte = byte_q;
endmodule
`default_nettype wire

// ### diag_seq_props.sv
// port checks for the diagnostic sequencer
`default_nettype none
module diag_seq_props #(
  parameter int CHECK_CYCLES = 10
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // host side and raw faults
  input wire logic [7:0] i_first_instruction_byte,
  input wire logic [7:0] i_second_instruction_byte,
  input wire logic i_write_done,
  input wire logic i_read_done,
  input wire diag_pkg::fault_raw_t [diag_pkg::NUM_CH-1:0] i_fault_raw,
  // results
  input wire logic [diag_pkg::NUM_CH-1:0] o_ch_enable,
  input wire logic o_clip_detector_sel10,
  input wire logic [7:0] o_diag_byte [diag_pkg::NUM_CH]
);
  localparam int LIM = 2 * CHECK_CYCLES + 8; // two ticks plus sync margin
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic diag_q; // diag enable as last written
  logic diag_d;
  int hi_q [diag_pkg::NUM_CH]; // edges with overload held high
  int hi_d [diag_pkg::NUM_CH];
  int lo_q [diag_pkg::NUM_CH]; // edges with overload low and no write
  int lo_d [diag_pkg::NUM_CH];
  // saturating counters keep the checks cheap for long holds
  always_comb
  begin
    diag_d = i_write_done ? i_first_instruction_byte[6] : diag_q;
    for (int c = 0; c < diag_pkg::NUM_CH; c++)
    begin
      hi_d[c] = i_fault_raw[c].overload ? hi_q[c] + int'(hi_q[c] < LIM) : 0;
      lo_d[c] = (i_fault_raw[c].overload || i_write_done) ? 0 : lo_q[c] + int'(lo_q[c] < LIM);
    end
  end
  // register the helper state
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      diag_q <= 1'b0;
      hi_q <= '{default: 0};
      lo_q <= '{default: 0};
    end
    else
    begin
      diag_q <= diag_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
  property p_clip_follow;
    i_write_done ##1 !i_write_done ##1 !i_write_done |-> o_clip_detector_sel10 == $past(i_first_instruction_byte[0], 2);
  endproperty
  a_clip_follow: assert property (p_clip_follow) else $error("clip select mismatch");
  property p_clip_hold;
    !i_write_done && !$past(i_write_done) && !$past(i_write_done, 2) |-> $stable(o_clip_detector_sel10);
  endproperty
  a_clip_hold: assert property (p_clip_hold) else $error("clip select moved");
  property p_spare_zero;
    o_diag_byte[0][5:4] == 2'h0 && o_diag_byte[1][7:4] == 4'h0 && o_diag_byte[2][7:4] == 4'h0
      && o_diag_byte[3][7:4] == 4'h0;
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("spare byte bits set");
  property p_done_clear;
    i_read_done && o_diag_byte[0][6] |-> ##[1:2] !o_diag_byte[0][6];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done kept after read");
  property p_done_fall;
    $fell(o_diag_byte[0][6]) |-> $past(i_read_done) || $past(i_read_done, 2) || $past(i_write_done)
      || $past(i_write_done, 2);
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done dropped without read");
  property p_done_diag;
    $rose(o_diag_byte[0][6]) |-> diag_q;
  endproperty
  a_done_diag: assert property (p_done_diag) else $error("cycle ended with diag off");
  for (genvar c = 0; c < diag_pkg::NUM_CH; c++)
  begin : g_ch
    property p_shut;
      hi_q[c] >= CHECK_CYCLES + 6 |-> !o_ch_enable[c];
    endproperty
    a_shut: assert property (p_shut) else $error("channel on under overload");
    property p_recover;
      !diag_q && lo_q[c] >= LIM |-> o_ch_enable[c];
    endproperty
    a_recover: assert property (p_recover) else $error("channel not restarted");
  end
endmodule
`default_nettype wire

// ### diag_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
`default_nettype none
module diag_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;  // first stage, read only by the second
  // plain two stage chain; no logic between the stages
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### output_fault_diagnostic_sequencer_tb_top.sv
// self-checking bench for the diagnostic sequencer
`default_nettype none
module output_fault_diagnostic_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHK = 10; // short tick keeps the run small
  localparam int CYC = 130 * CHK; // bound on one full cycle
  typedef struct packed {logic [7:0] ib1; logic [3:0] ovl; logic [3:0] en;} row_t;
  // restart-mode rows: first byte, overloaded channels, expected enables
  localparam row_t ROWS [4] = '{'{8'h01, 4'h0, 4'hf}, '{8'h00, 4'h5, 4'ha}, '{8'h01, 4'h8, 4'h7},
    '{8'h00, 4'h0, 4'hf}};
  logic i_core_clk, i_rst_b, i_write_done, i_read_done, o_clip_detector_sel10;
  logic [7:0] i_first_instruction_byte, i_second_instruction_byte;
  diag_pkg::fault_raw_t [diag_pkg::NUM_CH-1:0] i_fault_raw;
  logic [diag_pkg::NUM_CH-1:0] o_ch_enable;
  logic [7:0] o_diag_byte [diag_pkg::NUM_CH];
  int n_fail, checks, cyc;
  diag_seq #(.CHECK_CYCLES(CHK)) DUT (.i_core_clk, .i_rst_b, .i_first_instruction_byte,
    .i_second_instruction_byte, .i_write_done, .i_read_done, .i_fault_raw, .o_ch_enable,
    .o_clip_detector_sel10, .o_diag_byte);
  diag_host_model host (.i_core_clk, .o_ib1(i_first_instruction_byte), .o_ib2(i_second_instruction_byte),
    .o_write_done(i_write_done), .o_read_done(i_read_done));
  always #10ns i_core_clk = ~i_core_clk;
  task automatic test_done();
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // fault bits: gnd_pos gnd_neg vs load_pa load_ld offset overload
  task automatic put(input int c, input logic [6:0] v);
    @(negedge i_core_clk);
    i_fault_raw[c] = diag_pkg::fault_raw_t'(v);
  endtask
  task automatic run(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // bounded wait for the done flag
  task automatic wait_done();
    int n;
    n = 0;
    // a read just made needs two clocks before its cleared flag shows
    run(2);
    while (o_diag_byte[0][6] !== 1'b1 && n < CYC)
    begin
      @(negedge i_core_clk);
      n++;
    end
    cmp("done flag", 8'h01, {7'h00, o_diag_byte[0][6]});
    run(2);
  endtask
  // hang guard
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      test_done();
    end
  end
  initial
  begin
    i_core_clk = 1'b0;
    i_rst_b = 1'b0;
    i_fault_raw = '0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    run(20);
    cmp("byte0 in reset", 8'h00, o_diag_byte[0]);
    i_rst_b = 1'b1;
    foreach (ROWS[k])
    begin
      host.wr(ROWS[k].ib1, 8'h00);
      for (int c = 0; c < 4; c++)
        put(c, ROWS[k].ovl[c] ? 7'h41 : 7'h00);
      run(3 * CHK + 10);
      cmp("enable", {4'h0, ROWS[k].en}, {4'h0, o_ch_enable});
      cmp("clip", {7'h00, ROWS[k].ib1[0]}, {7'h00, o_clip_detector_sel10});
    end
    // short spike with diag armed: no cycle
    host.wr(8'h40, 8'h00);
    put(0, 7'h41);
    run(3);
    put(0, 7'h00);
    run(5 * CHK);
    cmp("enable after spike", 8'h0f, {4'h0, o_ch_enable});
    run(CYC);
    cmp("byte0 after spike", 8'h00, o_diag_byte[0]);
    // source ground plus supply short reports both
    put(2, 7'h51);
    wait_done();
    cmp("byte0 done", 8'h40, o_diag_byte[0]);
    cmp("byte2 pair", 8'h03, o_diag_byte[2]);
    cmp("enable restart", 8'h0b, {4'h0, o_ch_enable});
    put(2, 7'h31);
    run(CYC);
    cmp("byte2 held", 8'h03, o_diag_byte[2]);
    host.rd();
    run(2);
    cmp("byte0 after read", 8'h00, o_diag_byte[0]);
    cmp("byte2 after read", 8'h03, o_diag_byte[2]);
    wait_done();
    cmp("byte2 sink pair", 8'h02, o_diag_byte[2]);
    // load threshold by diagnostic mode
    put(2, 7'h00);
    put(1, 7'h05);
    host.rd();
    wait_done();
    cmp("byte1 amp mode", 8'h00, o_diag_byte[1]);
    host.wr(8'h50, 8'h08);
    host.rd();
    wait_done();
    cmp("byte1 line mode", 8'h08, o_diag_byte[1]);
    // offset windows
    put(1, 7'h00);
    put(3, 7'h02);
    host.wr(8'h60, 8'h00);
    run(50);
    host.rd();
    run(3);
    cmp("offset held", 8'h04, o_diag_byte[3]);
    put(3, 7'h00);
    run(10);
    put(3, 7'h02);
    run(10);
    host.rd();
    run(3);
    cmp("offset broken", 8'h00, o_diag_byte[3]);
    put(3, 7'h03);
    run(3);
    put(3, 7'h02);
    run(5 * CHK);
    host.rd();
    run(3);
    cmp("offset overload", 8'h00, o_diag_byte[3]);
    // a ground short that leaves mid-cycle is not reported, nor the load it masked
    put(0, 7'h49);
    run(30 * CHK);
    put(0, 7'h09);
    wait_done();
    cmp("byte0 unstable", 8'h40, o_diag_byte[0]);
    cmp("enable after cycle", 8'h0e, {4'h0, o_ch_enable});
    test_done();
  end
endmodule
bind diag_seq diag_seq_props #(.CHECK_CYCLES(CHECK_CYCLES)) props (.i_core_clk, .i_rst_b,
  .i_first_instruction_byte, .i_second_instruction_byte, .i_write_done, .i_read_done, .i_fault_raw,
  .o_ch_enable, .o_clip_detector_sel10, .o_diag_byte);
`default_nettype wire
